// *** logic/cpuc_core.sv ***
// Two-phase pipelined execution core with 8-bit ALU and mapped special registers
`timescale 1ns/1ps
`default_nettype none
module cpuc_core (
   input  wire logic                   ref_clk_in,
   input  wire logic                   nrst_in,
   input  wire logic                   external_reset_n_in,
   input  wire logic [11:0]            prog_data_in,
   input  wire logic [7:0]             data_rdata_in,
   output logic      [10:0]            prog_addr_out,
   output var cpuc_pkg::cpuc_dbus_t    data_bus_out,
   output logic      [7:0]             w_out,
   output logic      [7:0]             status_out
);
   import cpuc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   cpuc_phase_t state;
   logic [11:0] ir;
   logic        ir_valid;
   logic [10:0] program_counter;
   logic [7:0]  w;
   logic [7:0]  status;
   logic [7:0]  fsr;
   cpuc_dbus_t  dbus;
   logic        rst_s1;
   logic        rst_s2;

   // ----------------------------------------------------------------
   // Arithmetic helpers
   // ----------------------------------------------------------------
   function automatic logic [4:0] nib_add(input logic [3:0] a, input logic [3:0] b,
                                          input logic cin);
      nib_add = {1'b0, a} + {1'b0, b} + {4'h0, cin};
   endfunction : nib_add

   // Returns {carry, nibble carry, sum}
   function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
      logic [4:0] lo;
      logic [4:0] hi;
      lo   = nib_add(a[3:0], b[3:0], cin);
      hi   = nib_add(a[7:4], b[7:4], lo[4]);
      add8 = {hi[4], lo[4], hi[3:0], lo[3:0]};
   endfunction : add8

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire        core_rst = !nrst_in || !rst_s2;
   wire        exec_now = (state == PH_EXEC) && ir_valid;
   wire [4:0]  fld_f    = ir[4:0];
   wire        dest_f   = ir[5];
   wire [5:0]  op6      = ir[11:6];
   wire [3:0]  op4      = ir[11:8];
   wire [7:0]  lit      = ir[7:0];
   wire        is_byte  = (ir[11:10] == 2'b00);
   wire        is_bit   = (ir[11:10] == 2'b01);
   wire        is_lit   = (ir[11:10] == 2'b11);
   wire        is_goto  = (ir[11:9] == OP_GOTO);
   // Indirect access goes through the pointer register
   wire [7:0]  eff_addr = (fld_f == ADDR_INDF) ? fsr : {3'b000, fld_f};
   wire [4:0]  sel      = dbus.addr[4:0];
   wire        sel_indf = (sel == ADDR_INDF);
   wire        sel_pcl  = (sel == ADDR_PCL);
   wire        sel_stat = (sel == ADDR_STATUS);
   wire        sel_fsr  = (sel == ADDR_FSR);
   wire        sel_int  = sel_indf || sel_pcl || sel_stat || sel_fsr;
   wire [7:0]  bmask    = 8'h01 << ir[7:5];

   // File operand: specials answer internally, the rest from the file bus
   logic [7:0] opnd;
   always_comb begin
      if (sel_indf) begin
         opnd = 8'h00;                                    // Pointer at itself reads zero
      end else if (sel_pcl) begin
         opnd = program_counter[7:0];
      end else if (sel_stat) begin
         opnd = status;
      end else if (sel_fsr) begin
         opnd = fsr;
      end else begin
         opnd = data_rdata_in;
      end
   end

   // Shared adder results, all two's complement
   wire [9:0]  add_r = add8(opnd, w, 1'b0);
   wire [9:0]  sub_r = add8(opnd, ~w, 1'b1);
   wire [9:0]  inc_r = add8(opnd, 8'h00, 1'b1);
   wire [9:0]  dec_r = add8(opnd, 8'hFF, 1'b0);

   // ----------------------------------------------------------------
   // ALU
   // ----------------------------------------------------------------
   logic [7:0] res;
   logic       nc;
   logic       ndc;
   logic       uc;
   logic       udc;
   logic       uz;
   logic       wr_w;
   logic       wr_f;
   logic       skip;
   always_comb begin
      res  = opnd;
      nc   = status[C_BIT];
      ndc  = status[NC_BIT];
      uc   = 1'b0;
      udc  = 1'b0;
      uz   = 1'b0;
      wr_w = 1'b0;
      wr_f = 1'b0;
      skip = 1'b0;
      if (is_byte) begin
         wr_w = !dest_f;
         wr_f = dest_f;
         case (op6)
            OP_MOVWF: begin res = w; wr_w = 1'b0; end
            OP_CLR: begin res = 8'h00; uz = 1'b1; end
            OP_SUBWF: begin
               res = sub_r[7:0]; nc = sub_r[9]; ndc = sub_r[8];
               uc = 1'b1; udc = 1'b1; uz = 1'b1;
            end
            OP_DECF: begin res = dec_r[7:0]; uz = 1'b1; end
            OP_IORWF: begin res = opnd | w; uz = 1'b1; end
            OP_ANDWF: begin res = opnd & w; uz = 1'b1; end
            OP_XORWF: begin res = opnd ^ w; uz = 1'b1; end
            OP_ADDWF: begin
               res = add_r[7:0]; nc = add_r[9]; ndc = add_r[8];
               uc = 1'b1; udc = 1'b1; uz = 1'b1;
            end
            OP_MOVF: begin uz = 1'b1; end
            OP_COMF: begin res = ~opnd; uz = 1'b1; end
            OP_INCF: begin res = inc_r[7:0]; uz = 1'b1; end
            OP_DECFSZ: begin res = dec_r[7:0]; skip = (dec_r[7:0] == 8'h00); end
            OP_RRF: begin res = {status[C_BIT], opnd[7:1]}; nc = opnd[0]; uc = 1'b1; end
            OP_RLF: begin res = {opnd[6:0], status[C_BIT]}; nc = opnd[7]; uc = 1'b1; end
            OP_SWAPF: begin res = {opnd[3:0], opnd[7:4]}; end
            default: begin res = inc_r[7:0]; skip = (inc_r[7:0] == 8'h00); end
         endcase
      end else if (is_bit) begin
         case (op4)
            OP_BCF: begin res = opnd & ~bmask; wr_f = 1'b1; end
            OP_BSF: begin res = opnd | bmask; wr_f = 1'b1; end
            OP_BTFSC: begin skip = ((opnd & bmask) == 8'h00); end
            default: begin skip = ((opnd & bmask) != 8'h00); end
         endcase
      end else if (is_lit) begin
         wr_w = 1'b1;
         case (op4)
            OP_MOVLW: begin res = lit; end
            OP_IORLW: begin res = lit | w; uz = 1'b1; end
            OP_ANDLW: begin res = lit & w; uz = 1'b1; end
            default: begin res = lit ^ w; uz = 1'b1; end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Next-state selection
   // ----------------------------------------------------------------
   wire        wr_pcl   = wr_f && sel_pcl;
   wire        ext_wr   = wr_f && !sel_int;
   wire        branch   = is_goto || wr_pcl || skip;
   wire [10:0] goto_tgt = {program_counter[10:9], ir[8:0]};
   wire [7:0]  stat_base = (wr_f && sel_stat) ? res : status;
   wire [7:0]  next_status = {stat_base[7:3],
                              uz  ? (res == 8'h00) : stat_base[Z_BIT],
                              udc ? ndc : stat_base[NC_BIT],
                              uc  ? nc  : stat_base[C_BIT]};
   // Skips only step past the prefetched word; jumps reload the counter
   wire [10:0] next_pc = is_goto ? goto_tgt :
                         wr_pcl  ? {program_counter[10:8], res} :
                                   program_counter + 11'h001;
   wire        add_zero  = (add_r[7:0] == 8'h00);
   wire        add_nib_c = ({1'b0, opnd[3:0]} + {1'b0, w[3:0]}) > 5'h0F;
   wire        is_sub    = is_byte && (op6 == OP_SUBWF);
   wire        is_add    = is_byte && (op6 == OP_ADDWF);

   // ----------------------------------------------------------------
   // Reset pin synchroniser
   // ----------------------------------------------------------------
   // Pin is asynchronous to the core; two stages before use
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         rst_s1 <= 1'b1;
         rst_s2 <= 1'b1;
      end else begin
         rst_s1 <= external_reset_n_in;
         rst_s2 <= rst_s1;
      end
   end

   // ----------------------------------------------------------------
   // Phase sequencer, fetch and program counter
   // ----------------------------------------------------------------
   // First cycle after reset executes nothing; after a branch the prefetched word is dropped, costing one cycle
   always_ff @(posedge ref_clk_in) begin
      if (core_rst) begin
         state           <= PH_ADDR;
         ir              <= 12'h000;
         ir_valid        <= 1'b0;
         program_counter <= PCNT_RST;
      end else if (state == PH_ADDR) begin
         state <= PH_EXEC;
      end else begin
         state           <= PH_ADDR;
         ir              <= prog_data_in;
         ir_valid        <= !(ir_valid && branch);
         program_counter <= ir_valid ? next_pc : program_counter + 11'h001;
      end
   end

   // ----------------------------------------------------------------
   // Data bus: address in first phase, write strobe after execute
   // ----------------------------------------------------------------
   // Address stays put through the write so the file latches the right cell
   always_ff @(posedge ref_clk_in) begin
      if (core_rst) begin
         dbus <= '0;
      end else if (state == PH_ADDR) begin
         dbus.addr <= eff_addr;
         dbus.we   <= 1'b0;
      end else begin
         dbus.wdata <= res;
         dbus.we    <= exec_now && ext_wr;
      end
   end

   // ----------------------------------------------------------------
   // Architectural registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (core_rst) begin
         w      <= W_RST;
         status <= STATUS_RST;
         fsr    <= FSR_RST;
      end else if (exec_now) begin
         if (wr_w) begin
            w <= res;
         end
         if (wr_f && sel_fsr) begin
            fsr <= res;
         end
         status <= next_status;
      end
   end

   assign prog_addr_out = program_counter;
   assign data_bus_out  = dbus;
   assign w_out         = w;
   assign status_out    = status;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (core_rst);

   sequence seq_goto;
      exec_now && is_goto;
   endsequence
   sequence seq_bubble;
      !ir_valid [*2] ##1 ir_valid;
   endsequence
   sequence seq_pin_low;
      !external_reset_n_in ##1 !external_reset_n_in ##1 !external_reset_n_in;
   endsequence

   chk_phase_alternate: assert property (state == PH_ADDR |=>
      state == PH_EXEC ##1 state == PH_ADDR) else $error("phase sequence broken");
   chk_instr_capture: assert property (state == PH_EXEC |=>
      ir == $past(prog_data_in)) else $error("opcode word not latched");
   chk_goto_bubble: assert property (seq_goto |=>
      prog_addr_out == $past(goto_tgt) ##0 seq_bubble) else $error("branch timing wrong");
   chk_pc_advance: assert property (exec_now && !branch |=>
      prog_addr_out == $past(program_counter) + 11'h001) else $error("fetch did not advance");
   chk_fetch_with_write: assert property (exec_now && ext_wr |=>
      data_bus_out.we && ir == $past(prog_data_in)) else $error("write and fetch not parallel");
   chk_w_unmapped: assert property (exec_now && wr_w && !wr_f |=>
      !data_bus_out.we) else $error("accumulator write reached data bus");
   chk_sub_borrow: assert property (exec_now && is_sub && !(wr_f && sel_stat) |=>
      status[C_BIT] == ($past(opnd) >= $past(w))) else $error("borrow flag wrong");
   chk_add_flags: assert property (exec_now && is_add && !(wr_f && sel_stat) |=>
      status[NC_BIT] == $past(add_nib_c) && status[Z_BIT] == $past(add_zero))
      else $error("add flags wrong");
   chk_indirect_addr: assert property (state == PH_ADDR && fld_f == ADDR_INDF |=>
      data_bus_out.addr == $past(fsr)) else $error("indirect address wrong");
   chk_pin_reset: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      seq_pin_low |=> prog_addr_out == PCNT_RST && !data_bus_out.we)
      else $error("reset pin ignored");
   chk_instr_period: assert property (state == PH_ADDR |=>
      prog_addr_out == $past(prog_addr_out)) else $error("fetch address moved mid cycle");
endmodule : cpuc_core
`default_nettype wire

// *** logic/cpuc_pkg.sv ***
// Shared constants and types of the 8-bit execution core
package cpuc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 100;
   localparam int INSTR_CYCLE_NS = 200;
   localparam int CLKS_PER_INSTR = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int INSTR_W = 12;
   localparam int DATA_W  = 8;
   localparam int PCNT_W  = 11;

   // ----------------------------------------------------------------
   // Mapped special registers (low five address bits)
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_INDF   = 5'h00;
   localparam logic [4:0] ADDR_PCL    = 5'h02;
   localparam logic [4:0] ADDR_STATUS = 5'h03;
   localparam logic [4:0] ADDR_FSR    = 5'h04;

   // Status bit positions and reset values
   localparam int            C_BIT      = 0;
   localparam int            NC_BIT     = 1;
   localparam int            Z_BIT      = 2;
   localparam logic [7:0]    STATUS_RST = 8'h00;
   localparam logic [7:0]    FSR_RST    = 8'h00;
   localparam logic [7:0]    W_RST      = 8'h00;
   localparam logic [10:0]   PCNT_RST   = 11'h000;

   // ----------------------------------------------------------------
   // Opcodes: byte ops on bits 11:6, bit/literal ops on 11:8
   // ----------------------------------------------------------------
   localparam logic [5:0] OP_MOVWF  = 6'h00;
   localparam logic [5:0] OP_CLR    = 6'h01;
   localparam logic [5:0] OP_SUBWF  = 6'h02;
   localparam logic [5:0] OP_DECF   = 6'h03;
   localparam logic [5:0] OP_IORWF  = 6'h04;
   localparam logic [5:0] OP_ANDWF  = 6'h05;
   localparam logic [5:0] OP_XORWF  = 6'h06;
   localparam logic [5:0] OP_ADDWF  = 6'h07;
   localparam logic [5:0] OP_MOVF   = 6'h08;
   localparam logic [5:0] OP_COMF   = 6'h09;
   localparam logic [5:0] OP_INCF   = 6'h0A;
   localparam logic [5:0] OP_DECFSZ = 6'h0B;
   localparam logic [5:0] OP_RRF    = 6'h0C;
   localparam logic [5:0] OP_RLF    = 6'h0D;
   localparam logic [5:0] OP_SWAPF  = 6'h0E;
   localparam logic [5:0] OP_INCFSZ = 6'h0F;
   localparam logic [3:0] OP_BCF    = 4'h4;
   localparam logic [3:0] OP_BSF    = 4'h5;
   localparam logic [3:0] OP_BTFSC  = 4'h6;
   localparam logic [3:0] OP_BTFSS  = 4'h7;
   localparam logic [3:0] OP_MOVLW  = 4'hC;
   localparam logic [3:0] OP_IORLW  = 4'hD;
   localparam logic [3:0] OP_ANDLW  = 4'hE;
   localparam logic [3:0] OP_XORLW  = 4'hF;
   localparam logic [2:0] OP_GOTO   = 3'h5;

   typedef enum logic [1:0] {
      PH_ADDR = 2'b01,
      PH_EXEC = 2'b10
   } cpuc_phase_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       we;
   } cpuc_dbus_t;
endpackage : cpuc_pkg

// *** verif/cpuc_mem_model.sv ***
// Behavioural program memory and data register file facing the core
`timescale 1ns/1ps
`default_nettype none
module cpuc_mem_model (
   input  wire logic                 ref_clk_in,
   input  wire logic [10:0]          prog_addr_in,
   input  var  cpuc_pkg::cpuc_dbus_t data_bus_in,
   output logic      [11:0]          prog_data_out,
   output logic      [7:0]           data_rdata_out,
   output logic      [7:0]           spec_hits_out
);
   import cpuc_pkg::*;
   logic [11:0] rom [0:2047];
   logic [7:0]  ram [0:255];
   // -------------------------------------------------------------
   // Read paths
   // -------------------------------------------------------------
   // Fetch and data reads on separate paths, both combinational
   assign prog_data_out  = rom[prog_addr_in];
   assign data_rdata_out = ram[data_bus_in.addr];
   // -------------------------------------------------------------
   // Write path
   // -------------------------------------------------------------
   // Special addresses live inside the core, so a write here is counted
   logic [7:0] hit_count = 8'h00;
   assign spec_hits_out = hit_count;
   always @(posedge ref_clk_in) begin
      if (data_bus_in.we === 1'b1) begin
         ram[data_bus_in.addr] <= data_bus_in.wdata;
         if (data_bus_in.addr[4:0] inside {ADDR_INDF, ADDR_PCL, ADDR_STATUS, ADDR_FSR}) begin
            hit_count <= hit_count + 8'h01;
         end
      end
   end
endmodule : cpuc_mem_model
`default_nettype wire

// *** verif/tb_cpuc_core.sv ***
// Self-checking bench: random and corner programs run on the core
`timescale 1ns/1ps
`default_nettype none
module tb_cpuc_core;
   import cpuc_pkg::*;
   localparam logic [5:0] BYTE_OPS [16] = '{OP_MOVWF, OP_CLR, OP_SUBWF, OP_DECF, OP_IORWF,
      OP_ANDWF, OP_XORWF, OP_ADDWF, OP_MOVF, OP_COMF, OP_INCF, OP_RRF, OP_RLF, OP_SWAPF,
      OP_DECFSZ, OP_INCFSZ};
   logic        ref_clk_in, nrst_in, ext_rst_n;
   logic [11:0] prog_data;
   logic [7:0]  rdata, w, st, hits, rw, rs, rfsr;
   logic [10:0] fetch_addr;
   cpuc_dbus_t  dbus;
   logic [31:0] seed;
   logic [7:0]  rmem [0:255];
   logic [11:0] prog [$];
   logic [7:0]  ew [$];
   logic [7:0]  es [$];
   int          err_count, n_tests, ns;

   cpuc_core i_cpuc_core (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
      .external_reset_n_in(ext_rst_n), .prog_data_in(prog_data), .data_rdata_in(rdata),
      .prog_addr_out(fetch_addr), .data_bus_out(dbus), .w_out(w), .status_out(st));
   cpuc_mem_model i_cpuc_mem_model (.ref_clk_in(ref_clk_in), .prog_addr_in(fetch_addr),
      .data_bus_in(dbus), .prog_data_out(prog_data), .data_rdata_out(rdata),
      .spec_hits_out(hits));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // Repeatable xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Reference execution of one word; sk tells the caller to drop the next word
   task automatic ref_exec(input logic [11:0] ins, output logic sk);
      logic [7:0] fa, fv, res, bm;
      logic [8:0] s9;
      logic [5:0] op;
      sk  = 1'b0;
      bm  = 8'h01 << ins[7:5];
      op  = ins[11:6];
      fa  = (ins[4:0] == 5'h00) ? rfsr : {3'h0, ins[4:0]};
      fv  = rmem[fa];
      s9  = {1'b0, fv} + {1'b0, rw};
      res = fv;
      if (ins[11:10] == 2'b11) begin
         case (ins[9:8])
            2'h0: res = ins[7:0];
            2'h1: res = rw | ins[7:0];
            2'h2: res = rw & ins[7:0];
            default: res = rw ^ ins[7:0];
         endcase
         if (ins[9:8] != 2'h0) rs[Z_BIT] = (res == 8'h00);
         rw = res;
      end else if (ins[11:10] == 2'b01) begin
         case (ins[9:8])
            2'h0: rmem[fa] = fv & ~bm;
            2'h1: rmem[fa] = fv | bm;
            2'h2: sk = ((fv & bm) == 8'h00);
            default: sk = ((fv & bm) != 8'h00);
         endcase
      end else begin
         case (op)
            OP_MOVWF: res = rw;
            OP_CLR:   res = 8'h00;
            OP_SUBWF: begin
               s9 = {1'b0, fv} + {1'b0, ~rw} + 9'h001;
               rs[NC_BIT] = (fv[3:0] >= rw[3:0]);
            end
            OP_ADDWF: rs[NC_BIT] = (({1'b0, fv[3:0]} + {1'b0, rw[3:0]}) > 5'h0F);
            OP_DECF:  res = fv - 8'h01;
            OP_INCF:  res = fv + 8'h01;
            OP_DECFSZ: begin
               res = fv - 8'h01;
               sk = (res == 8'h00);
            end
            OP_INCFSZ: begin
               res = fv + 8'h01;
               sk = (res == 8'h00);
            end
            OP_IORWF: res = rw | fv;
            OP_ANDWF: res = rw & fv;
            OP_XORWF: res = rw ^ fv;
            OP_COMF:  res = ~fv;
            OP_SWAPF: res = {fv[3:0], fv[7:4]};
            OP_RRF: begin
               res = {rs[C_BIT], fv[7:1]};
               rs[C_BIT] = fv[0];
            end
            OP_RLF: begin
               res = {fv[6:0], rs[C_BIT]};
               rs[C_BIT] = fv[7];
            end
            default: res = fv;
         endcase
         if (op inside {OP_SUBWF, OP_ADDWF}) begin
            res = s9[7:0];
            rs[C_BIT] = s9[8];
         end
         if (op inside {OP_CLR, OP_SUBWF, OP_DECF, OP_IORWF, OP_ANDWF, OP_XORWF, OP_ADDWF,
                        OP_MOVF, OP_COMF, OP_INCF}) rs[Z_BIT] = (res == 8'h00);
         if (!ins[5]) rw = res;
         else if (fa[4:0] == ADDR_FSR) rfsr = res;
         else rmem[fa] = res;
      end
   endtask : ref_exec

   // Corner prelude (indirect pointer, borrow, nibble carry), then random words
   task automatic build();
      logic [31:0] r;
      int          k;
      logic        sk;
      rw = W_RST;
      rs = STATUS_RST;
      rfsr = FSR_RST;
      ew.delete();
      es.delete();
      for (int a = 0; a < 256; a++) begin
         r = rnd();
         rmem[a] = (a == 8'h11) ? 8'h00 : r[7:0];
         i_cpuc_mem_model.ram[a] = rmem[a];
      end
      r = rnd();
      prog = '{{8'hC1, r[3:0]}, 12'h024, 12'hC01, 12'h0B1, 12'hC0F, 12'h1D1};
      for (int i = 0; i < 20; i++) begin
         r = rnd();
         k = int'(r[31:16]) % 24;
         if (k < 16) prog.push_back({BYTE_OPS[k], (k == 0) | r[12],
                                     r[8] ? 5'h00 : {1'b1, r[3:0]}});
         else if (k < 20) prog.push_back({2'b11, 2'(k - 16), r[15:8]});
         else prog.push_back({2'b01, r[14:13], r[7:5], r[8] ? 5'h00 : {1'b1, r[3:0]}});
      end
      // Trailing no-op, so a final skip never lands on the jump below
      prog.push_back(12'h000);
      ns = prog.size();
      sk = 1'b0;
      foreach (prog[i]) begin
         if (sk) sk = 1'b0;
         else ref_exec(prog[i], sk);
         ew.push_back(rw);
         es.push_back(rs);
      end
      // Jump over a poison word, then park in a self loop
      prog.push_back({3'h5, 9'(ns + 2)});
      prog.push_back(12'hCA5);
      prog.push_back({3'h5, 9'(ns + 2)});
      for (int a = 0; a < 2048; a++) i_cpuc_mem_model.rom[a] = (a < prog.size()) ? prog[a] : 12'h000;
   endtask : build

   // Compare tasks, one per result kind
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_byte

   task automatic chk_addr(input string nm, input logic [10:0] e, input logic [10:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_addr

   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   // -------------------------------------------------------------
   // Clock, watchdog and main sequence
   // -------------------------------------------------------------
   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end

   // Three programs of about 100 clocks each; 1000 clocks is ample
   initial begin
      #100000;
      err_count++;
      $display("watchdog expired");
      wrap_up();
   end

   initial begin
      err_count = 0;
      n_tests = 0;
      seed = 32'd81358;
      nrst_in = 1'b0;
      ext_rst_n = 1'b1;
      for (int r = 0; r < 3; r++) begin
         if (r > 0) begin
            @(posedge ref_clk_in);
            #1 ext_rst_n = 1'b0;
            repeat (6) @(posedge ref_clk_in);
            @(negedge ref_clk_in);
            chk_addr("fetch_in_reset", PCNT_RST, fetch_addr);
            chk_byte("w_in_reset", W_RST, w);
            chk_byte("st_in_reset", STATUS_RST, st);
         end
         build();
         repeat (6) @(posedge ref_clk_in);
         #1 nrst_in = 1'b1;
         ext_rst_n = 1'b1;
         if (r == 0) begin
            // One word per two clocks: results land at edge 2(i+2)
            repeat (4) @(posedge ref_clk_in);
            @(negedge ref_clk_in);
            for (int i = 0; i < ns; i++) begin
               chk_byte("w_step", ew[i], w);
               chk_byte("st_step", es[i], st);
               chk_addr("fetch_step", 11'(i + 2), fetch_addr);
               repeat (CLKS_PER_INSTR) @(posedge ref_clk_in);
               @(negedge ref_clk_in);
            end
         end
         // Parked loop shows its target only every other cycle; land on one
         repeat ((r == 0) ? 28 : 2 * ns + 30) @(posedge ref_clk_in);
         @(negedge ref_clk_in);
         chk_addr("fetch_loop", 11'(ns + 2), fetch_addr);
         chk_byte("w_end", rw, w);
         chk_byte("st_end", rs, st);
         for (int a = 8'h10; a < 8'h20; a++) begin
            chk_byte("file", rmem[a], i_cpuc_mem_model.ram[a]);
         end
         chk_byte("special_writes", 8'h00, hits);
      end
      wrap_up();
   end
endmodule : tb_cpuc_core
`default_nettype wire
